// ==== verilog/bes_pkg.sv ====
// Shared constants and types for the bus error status logging block
package bes_pkg;
	localparam int BANKS = 5;
	localparam logic [2:0] MAIN_BANK = 3'h4;

	// Register byte offsets, two words per bank status
	localparam logic [7:0] OFS_BANK0_LO = 8'h00;
	localparam logic [7:0] OFS_BANK_STRIDE = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h28;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
	localparam logic [5:0] BANK_WORDS = 6'h0a;

	// Field positions inside a bank status word
	localparam int CODE_LSB = 0;
	localparam int FLAG_LSB = 16;
	localparam int BIT_ADDR_PAR = 16;
	localparam int BIT_RESP_HARD = 17;
	localparam int BIT_RESP_PAR = 18;
	localparam int BIT_DATA_PAR = 19;
	localparam int BIT_INV_REQ = 20;
	localparam int BIT_PAD_SM = 21;
	localparam int BIT_DSTB_GLITCH = 22;
	localparam int BIT_ASTB_GLITCH = 23;
	localparam int BIT_UC = 61;
	localparam int BIT_OVER = 62;
	localparam int BIT_VAL = 63;

	// Writable bits, low and high word; 56:24 stay zero
	localparam logic [31:0] LO_WMASK = 32'h00ff_ffff;
	localparam logic [31:0] HI_WMASK = 32'hfe00_0000;
	localparam logic [31:0] INV_REQ_MASK = 32'h0010_0000;

	// Fixed leading bits of the two compound code formats
	localparam logic [3:0] BUS_CODE_TOP = 4'h0;
	localparam logic [0:0] BUS_CODE_ONE = 1'h1;
	localparam logic [7:0] CACHE_CODE_TOP = 8'h01;

	// Revision that reports the invalid interrupt-unit request; arbitrary
	localparam logic [31:0] SIG_INV_REQ = 32'h0000_00a5;

	// Reset values
	localparam logic [63:0] STATUS_RST = 64'h0;
	localparam logic [4:0] IRQ_RST = 5'h00;
	localparam logic [31:0] DATA_RST = 32'h0;

	typedef logic [63:0] bes_status_t;
endpackage

// ==== verilog/bes_acc_if.sv ====
// Register access carrier between bus front end and register file
`timescale 1ns/1ps
interface bes_acc_if;
	logic acc;
	logic we;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdata;
	logic [31:0] rdata;

	modport front (output acc, output we, output adr, output sel,
		output wdata, input rdata);
	modport regs (input acc, input we, input adr, input sel,
		input wdata, output rdata);
endinterface

// ==== verilog/bes_wb_slave.sv ====
// Classic Wishbone slave front end, one wait state, registered answer
`timescale 1ns/1ps
module bes_wb_slave import bes_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	bes_acc_if.front acc_if
);
	logic ack_reg;
	logic ack_next;
	logic [31:0] dat_reg;
	logic [31:0] dat_next;

	always_comb begin
		// Blocked while ack is up so a held request acts only once
		ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
		acc_if.acc = ack_next;
		acc_if.we = wb_we_i;
		acc_if.adr = wb_adr_i;
		acc_if.sel = wb_sel_i;
		acc_if.wdata = wb_dat_i;
		dat_next = (ack_next & ~wb_we_i) ? acc_if.rdata : DATA_RST;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= DATA_RST;
		end else begin
			ack_reg <= ack_next;
			dat_reg <= dat_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;
endmodule

// ==== verilog/bes_top.sv ====
// Machine check bank status logging for front bus and cache errors
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - Bus errors log code 0000 1PPT RRRR IILL in status bits 15:0.
// - Bit 16 set on front bus address parity error, else zero.
// - Bit 17 set on hardware failure in a received response.
// - Bit 18 set on response phase parity error.
// - Bit 19 set on data parity error, interrupt unit or front bus.
// - Bit 20 flags invalid interrupt-unit request on one revision only.
// - Bits 21, 22, 23 flag pad tracker, data and address strobe glitches.
// - Cache errors log code 0000 0001 RRRR TTLL in status bits 15:0.
// - Five banks, each with a 64-bit status register.
// - Fifth bank is main log, accepts both cache and bus codes.
module bes_top import bes_pkg::*; #(
	parameter logic [31:0] PROC_SIGNATURE = SIG_INV_REQ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic log_valid_i,
	input wire logic [2:0] log_bank_i,
	input wire logic log_cache_i,
	input wire logic log_uc_i,
	input wire logic [1:0] log_pp_i,
	input wire logic log_t_i,
	input wire logic [3:0] log_req_i,
	input wire logic [1:0] log_ii_i,
	input wire logic [1:0] log_ll_i,
	input wire logic [7:0] log_flags_i,
	output logic irq_o
);
	bes_acc_if acc_if();

	bes_wb_slave u_front (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.acc_if(acc_if)
	);

	// Only the matching revision may ever hold the invalid-request bit
	localparam logic INV_REQ_EN = (PROC_SIGNATURE == SIG_INV_REQ);
	localparam logic [31:0] LO_MASK = INV_REQ_EN ? LO_WMASK :
		(LO_WMASK & ~INV_REQ_MASK);

	bes_status_t status_reg [BANKS];
	bes_status_t status_next [BANKS];
	logic [4:0] irq_stat_reg;
	logic [4:0] irq_stat_next;
	logic [4:0] irq_mask_reg;
	logic [4:0] irq_mask_next;
	logic irq_reg;
	logic irq_next;

	// Compound code for either format
	function automatic logic [15:0] make_code(input logic cache,
		input logic [1:0] pp, input logic t, input logic [3:0] req,
		input logic [1:0] ii, input logic [1:0] ll);
		logic [15:0] code;
		code = 16'h0000;
		if (cache) begin
			code = {CACHE_CODE_TOP, req, ii, ll};
		end else begin
			code = {BUS_CODE_TOP, BUS_CODE_ONE, pp, t, req, ii,
				ll};
		end
		return code;
	endfunction

	// Byte-lane write mask from Wishbone select
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
	endfunction

	logic [5:0] word_idx;
	logic [2:0] acc_bank;
	logic acc_hi;
	logic acc_in_bank;
	logic [2:0] tgt_bank;
	logic [31:0] wmask;
	logic [15:0] new_code;
	logic [7:0] new_flags;

	always_comb begin
		word_idx = acc_if.adr[7:2];
		acc_bank = word_idx[3:1];
		acc_hi = word_idx[0];
		acc_in_bank = (word_idx < BANK_WORDS);
		wmask = lane_mask(acc_if.sel);
		new_code = make_code(log_cache_i, log_pp_i, log_t_i, log_req_i,
			log_ii_i, log_ll_i);
		// Model-specific flags belong to the bus format only
		new_flags = log_cache_i ? 8'h00 : log_flags_i;
		if (!INV_REQ_EN) begin
			new_flags[BIT_INV_REQ - FLAG_LSB] = 1'b0;
		end
		// Cache codes, and out-of-range banks, land in the main log
		if (log_cache_i || (log_bank_i > MAIN_BANK)) begin
			tgt_bank = MAIN_BANK;
		end else begin
			tgt_bank = log_bank_i;
		end
	end

	// Read decode; unmapped words read zero
	always_comb begin
		acc_if.rdata = DATA_RST;
		if (acc_in_bank) begin
			if (acc_hi) begin
				acc_if.rdata = status_reg[acc_bank][63:32];
			end else begin
				acc_if.rdata = status_reg[acc_bank][31:0];
			end
		end else if (acc_if.adr == OFS_IRQ_STATUS) begin
			acc_if.rdata = {27'h0, irq_stat_reg};
		end else if (acc_if.adr == OFS_IRQ_MASK) begin
			acc_if.rdata = {27'h0, irq_mask_reg};
		end
	end

	always_comb begin
		logic [63:0] cur;
		logic [4:0] irq_set;
		logic [4:0] irq_clr;
		cur = STATUS_RST;
		irq_set = 5'h00;
		irq_clr = 5'h00;
		irq_mask_next = irq_mask_reg;
		for (int b = 0; b < BANKS; b++) begin
			cur = status_reg[b];
			if (acc_if.acc && acc_if.we && acc_in_bank &&
				(acc_bank == 3'(b))) begin
				if (acc_hi) begin
					cur[63:32] = (cur[63:32] & ~(wmask & HI_WMASK)) |
						(acc_if.wdata & wmask & HI_WMASK);
				end else begin
					cur[31:0] = (cur[31:0] & ~(wmask & LO_MASK)) |
						(acc_if.wdata & wmask & LO_MASK);
				end
			end
			// Logging after the write so a new error is never lost
			if (log_valid_i && (tgt_bank == 3'(b))) begin
				cur[BIT_OVER] = cur[BIT_VAL];
				cur[BIT_VAL] = 1'b1;
				cur[BIT_UC] = log_uc_i;
				cur[15:0] = new_code;
				// Bits 23:16, cleared when absent
				cur[BIT_ADDR_PAR] = new_flags[0];
				cur[BIT_RESP_HARD] = new_flags[1];
				cur[BIT_RESP_PAR] = new_flags[2];
				cur[BIT_DATA_PAR] = new_flags[3];
				cur[BIT_INV_REQ] = new_flags[4];
				cur[BIT_PAD_SM] = new_flags[5];
				cur[BIT_DSTB_GLITCH] = new_flags[6];
				cur[BIT_ASTB_GLITCH] = new_flags[7];
				irq_set[b] = 1'b1;
			end
			cur[56:24] = 33'h0;
			status_next[b] = cur;
		end
		if (acc_if.acc && acc_if.we) begin
			if (acc_if.adr == OFS_IRQ_STATUS && acc_if.sel[0]) begin
				irq_clr = acc_if.wdata[4:0];
			end
			if (acc_if.adr == OFS_IRQ_MASK && acc_if.sel[0]) begin
				irq_mask_next = acc_if.wdata[4:0];
			end
		end
		// Set wins over a same-cycle write-one clear
		irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
		irq_next = |(irq_stat_next & irq_mask_next);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int b = 0; b < BANKS; b++) begin
				status_reg[b] <= STATUS_RST;
			end
			irq_stat_reg <= IRQ_RST;
			irq_mask_reg <= IRQ_RST;
			irq_reg <= 1'b0;
		end else begin
			for (int b = 0; b < BANKS; b++) begin
				status_reg[b] <= status_next[b];
			end
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_reg <= irq_next;
		end
	end

	assign irq_o = irq_reg;
endmodule

// ==== dv/bes_top_asserts.sv ====
// Port-level assertions for the bus error status block
`timescale 1ns/1ps
module bes_top_asserts import bes_pkg::*; #(
	parameter logic [31:0] PROC_SIGNATURE = SIG_INV_REQ
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic log_valid_i,
	input wire logic [2:0] log_bank_i,
	input wire logic log_cache_i,
	input wire logic [1:0] log_pp_i,
	input wire logic log_t_i,
	input wire logic [3:0] log_req_i,
	input wire logic [1:0] log_ii_i,
	input wire logic [1:0] log_ll_i,
	input wire logic [7:0] log_flags_i,
	input wire logic irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bit 20 only counts on the matching revision
	localparam logic [7:0] FMASK =
		(PROC_SIGNATURE == SIG_INV_REQ) ? 8'hff : 8'hef;
	sequence take_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence rd_s(a);
		take_s and !wb_we_i && wb_adr_i == a;
	endsequence
	sequence bus_log_s;
		log_valid_i && !log_cache_i && log_bank_i == 3'h0;
	endsequence
	sequence cache_log_s;
		log_valid_i && log_cache_i;
	endsequence
	ack_timing_a: assert property (take_s |=> wb_ack_o)
		else $error("ack late");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!(wb_ack_o && !wb_we_i) |-> wb_dat_o == 32'h0)
		else $error("read data outside read ack");
	irq_reset_a: assert property ($fell(rst_i) |-> !irq_o)
		else $error("irq after reset");
	bus_code_a: assert property (bus_log_s ##1 rd_s(8'h00) |=>
		wb_dat_o == {8'h00, $past(log_flags_i, 2) & FMASK, 5'h01,
		$past(log_pp_i, 2), $past(log_t_i, 2), $past(log_req_i, 2),
		$past(log_ii_i, 2), $past(log_ll_i, 2)})
		else $error("bus code or flags wrong");
	cache_code_a: assert property (cache_log_s ##1 rd_s(8'h20) |=>
		wb_dat_o == {16'h0, 8'h01, $past(log_req_i, 2),
		$past(log_ii_i, 2), $past(log_ll_i, 2)})
		else $error("cache code wrong");
	reserved_zero_a: assert property (take_s and !wb_we_i &&
		wb_adr_i < 8'h28 |=> ($past(wb_adr_i[2]) ?
		wb_dat_o[24:0] == 25'h0 : wb_dat_o[31:24] == 8'h0))
		else $error("reserved bits set");
endmodule

bind bes_top bes_top_asserts #(.PROC_SIGNATURE(PROC_SIGNATURE)) bes_top_asserts_i (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
	.wb_ack_o, .log_valid_i, .log_bank_i, .log_cache_i, .log_pp_i, .log_t_i,
	.log_req_i, .log_ii_i, .log_ll_i, .log_flags_i, .irq_o);

// ==== dv/bes_top_tb.sv ====
// Self-checking bench for the bus error status block
`timescale 1ns/1ps
module bes_top_tb import bes_pkg::*; ;
	typedef struct packed {
		logic [2:0] bank;
		logic c;
		logic uc;
		logic [10:0] sub;
		logic [7:0] fl;
		logic [31:0] lo;
		logic [31:0] hi;
	} bes_row_t;
	bes_row_t rows [6];
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
	logic log_valid_i, log_cache_i, log_uc_i, log_t_i;
	logic [7:0] wb_adr_i, log_flags_i, base;
	logic [3:0] wb_sel_i, log_req_i;
	logic [31:0] wb_dat_i, wb_dat_o, q, q_alt, dat_alt;
	logic [2:0] log_bank_i;
	logic [1:0] log_pp_i, log_ii_i, log_ll_i;
	int mismatches, n_tests;

	bes_top bes_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
		.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .log_valid_i,
		.log_bank_i, .log_cache_i, .log_uc_i, .log_pp_i, .log_t_i, .log_req_i,
		.log_ii_i, .log_ll_i, .log_flags_i, .irq_o);

	// Other revision: bit 20 must never set or be writable
	bes_top #(.PROC_SIGNATURE(32'h0)) bes_top_alt_i (.clk_i, .rst_i,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o(dat_alt), .wb_ack_o(), .log_valid_i, .log_bank_i,
		.log_cache_i, .log_uc_i, .log_pp_i, .log_t_i, .log_req_i,
		.log_ii_i, .log_ll_i, .log_flags_i, .irq_o());

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic finish_test();
		if (mismatches == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// Also ends a one-cycle log pulse started just before
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s = 4'hf);
		@(posedge clk_i);
		log_valid_i <= 1'b0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		// No count of our own: only the watchdog ends a hang
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		q_alt = dat_alt;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic log_evt(input bes_row_t r);
		@(posedge clk_i);
		log_valid_i <= 1'b1;
		log_bank_i <= r.bank;
		log_cache_i <= r.c;
		log_uc_i <= r.uc;
		{log_pp_i, log_t_i, log_req_i, log_ii_i, log_ll_i} <= r.sub;
		log_flags_i <= r.fl;
	endtask

	initial begin
		rst_i = 1'b1;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, log_valid_i} = '0;
		{log_bank_i, log_cache_i, log_uc_i, log_pp_i, log_t_i} = '0;
		{log_req_i, log_ii_i, log_ll_i, log_flags_i} = '0;
		wb_sel_i = 4'hf;
		mismatches = 0;
		n_tests = 0;
		rows = '{'{3'h0, 1'b0, 1'b0, 11'h5a5, 8'h0f, 32'h000f_0da5, 32'h8000_0000},
			'{3'h1, 1'b0, 1'b1, 11'h2c3, 8'hf0, 32'h00f0_0ac3, 32'ha000_0000},
			'{3'h2, 1'b0, 1'b0, 11'h000, 8'h55, 32'h0055_0800, 32'h8000_0000},
			'{3'h3, 1'b0, 1'b0, 11'h7ff, 8'haa, 32'h00aa_0fff, 32'h8000_0000},
			'{3'h1, 1'b1, 1'b1, 11'h7ff, 8'hff, 32'h0000_01ff, 32'ha000_0000},
			'{3'h7, 1'b0, 1'b0, 11'h123, 8'h81, 32'h0081_0923, 32'hc000_0000}};
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			base = {2'h0, (rows[i].c || rows[i].bank > MAIN_BANK) ? MAIN_BANK :
				rows[i].bank, 3'h0};
			log_evt(rows[i]);
			bus(1'b0, base, 32'h0);
			chk(q, rows[i].lo);
			chk(q_alt, rows[i].lo & ~INV_REQ_MASK);
			bus(1'b0, base + 8'h04, 32'h0);
			chk(q, rows[i].hi);
		end
		bus(1'b0, OFS_IRQ_STATUS, 32'h0);
		chk(q, 32'h1f);
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b1, OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h1);
		bus(1'b1, OFS_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_o}, 32'h0);
		bus(1'b0, OFS_IRQ_STATUS, 32'h0);
		chk(q, 32'h1e);
		bus(1'b1, 8'h00, 32'hffff_ffff);
		bus(1'b0, 8'h00, 32'h0);
		chk(q, 32'h00ff_ffff);
		chk(q_alt, 32'h00ef_ffff);
		// Lane 1 only: bits 15:8 clear, the rest stays
		bus(1'b1, 8'h00, 32'h0, 4'h2);
		bus(1'b0, 8'h00, 32'h0);
		chk(q, 32'h00ff_00ff);
		bus(1'b1, 8'h04, 32'hffff_ffff);
		bus(1'b0, 8'h04, 32'h0);
		chk(q, 32'hfe00_0000);
		bus(1'b0, 8'h30, 32'h0);
		chk(q, 32'h0);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, 8'h24, 32'h0);
		chk(q, 32'h0);
		bus(1'b0, OFS_IRQ_MASK, 32'h0);
		chk(q, 32'h0);
		finish_test();
	end

	initial begin
		repeat (3000) @(posedge clk_i);
		mismatches++;
		finish_test();
	end
endmodule
